// file: rtl/iam_defs.svh
`ifndef IAM_DEFS_SVH
`define IAM_DEFS_SVH
`define IAM_A_IND0 8'h00
`define IAM_A_PTR0 8'h01
`define IAM_A_IND1 8'h02
`define IAM_A_PTR1L 8'h03
`define IAM_A_PTR1S 8'h04
`define IAM_A_ACC 8'h05
`define IAM_A_PCL 8'h06
`define IAM_A_TABLE_POINTER_LOW 8'h07
`define IAM_A_TABLE_HIGH_RESULT 8'h08
`define IAM_A_TABLE_POINTER_HIGH 8'h09
`define IAM_A_IND2 8'h0b
`define IAM_A_PTR2L 8'h0c
`define IAM_A_PTR2S 8'h0d
`define IAM_A_UNLOCK 8'h44
`define IAM_PAT_FIRST 8'h55
`define IAM_PAT_SECOND 8'haa
`define IAM_UNLOCK_RST 8'h00
`define IAM_MAP_SLOW_PERIODS 3'h4
`define IAM_OPT_BASE 8'hc0
`endif

// file: rtl/iam_pkg.sv
package iam_pkg;
  typedef enum logic [1:0] {
    IAM_OP_NONE,
    IAM_OP_READ,
    IAM_OP_WRITE
  } iam_op_t;
  typedef enum logic [1:0] {
    IAM_ST_IDLE,
    IAM_ST_ARMED,
    IAM_ST_MAPPED
  } iam_unlock_st_t;
endpackage : iam_pkg

// file: rtl/iam_core.sv
`timescale 1ns/1ps
`include "iam_defs.svh"
// How it works
// RQ1: Five pointer registers, ordinary read/write storage.
// RQ2: Indirect register access goes to pointed location.
// RQ3: Pointer zero reaches sector zero only.
// RQ4: Pointer pairs: high picks sector, low location.
// RQ5: Extended direct operand: sector plus location.
// RQ6: Extended operand carries ten significant bits.
// RQ7: Indirect to indirect register: read zero, no write.
// RQ8: Accumulator takes ALU results; transfers pass it.
// RQ9: Program counter low write jumps within page.
// RQ10: Program counter low write adds dummy cycle.
// RQ11: Software loads table pointers; increment allowed.
// RQ12: Table read: high byte kept, low to memory.
// RQ13: Sixty-four option words, table-read while mapped.
// RQ14: Unlock needs 55 then AA back to back.
// RQ15: Gap or wrong value leaves mapping off.
// RQ16: Option words appear at last page C0 to FF.
// RQ17: Mapping ends after four slow oscillator periods.
// RQ18: Each new unlock restarts the mapping timer.
// RQ19: Software masks interrupts around the unlock pattern.
// RQ20: Page-relative table read needs last-page pointer.
// RQ21: Unlock register eight bits, resets zero.
// RQ22: Wake from idle or sleep clears unlock register.
module iam_core #(
  parameter int PC_WIDTH = 11,
  parameter int SECTOR_BITS = 2
) (
  input wire logic REF_CLK,
  input wire logic SYS_RST,
  input wire logic [1:0] OP,
  input wire logic [9:0] ADDR,
  input wire logic [7:0] WDATA,
  input wire logic ACC_LOAD,
  input wire logic [7:0] ACC_IN,
  input wire logic [2:0] PTR_STEP,
  input wire logic [2:0] PTR_STEP_SEL,
  input wire logic TBL_READ,
  input wire logic TBL_LAST_PAGE,
  input wire logic [15:0] PROG_WORD,
  input wire logic [15:0] OPT_WORD,
  input wire logic SLOW_OSC,
  input wire logic WAKE,
  input wire logic [PC_WIDTH-1:0] PC_NOW,
  output logic [7:0] RDATA,
  output logic [9:0] MEM_ADDR,
  output logic MEM_RD,
  output logic MEM_WR,
  output logic [7:0] MEM_WDATA,
  output logic [7:0] ACC,
  output logic [PC_WIDTH-1:0] PC_JUMP,
  output logic PC_LOAD,
  output logic DUMMY_CYCLE,
  output logic [PC_WIDTH-1:0] PROG_ADDR,
  output logic [5:0] OPT_ADDR,
  output logic OPT_SEL,
  output logic MAP_ACTIVE
);
  if (PC_WIDTH < 9 || PC_WIDTH > 16 || SECTOR_BITS < 1 || SECTOR_BITS > 2) begin : g_param_check
    $error("iam_core: unsupported parameter values");
  end

  typedef struct packed {
    logic [7:0] ptr0;
    logic [7:0] ptr1l;
    logic [7:0] ptr1s;
    logic [7:0] ptr2l;
    logic [7:0] ptr2s;
    logic [7:0] acc;
    logic [7:0] table_pointer_low;
    logic [7:0] table_pointer_high;
    logic [7:0] table_high_result;
    logic [7:0] unlock;
    iam_pkg::iam_unlock_st_t ust;
    logic [2:0] slow_cnt;
    logic [2:0] osc_sync;
    logic [1:0] wake_sync;
    logic [7:0] rdata;
    logic [9:0] mem_addr;
    logic mem_rd;
    logic mem_wr;
    logic [7:0] mem_wdata;
    logic [PC_WIDTH-1:0] pc_jump;
    logic pc_load;
    logic dummy;
    logic [PC_WIDTH-1:0] prog_addr;
    logic [5:0] opt_addr;
    logic opt_sel;
    logic map_on;
    logic tbl_pend;
    logic [9:0] tbl_dest;
  } iam_state_t;

  iam_state_t s_q;
  iam_state_t s_d;

  // Turns an indirect register address into the effective memory address.
  function automatic logic [9:0] ind_target(input logic [7:0] a, input iam_state_t s);
    logic [9:0] t;
    t = 10'h000;
    unique case (a)
      `IAM_A_IND0: t = {2'b00, s.ptr0}; // RQ3
      `IAM_A_IND1: t = {2'(s.ptr1s[SECTOR_BITS-1:0]), s.ptr1l}; // RQ4
      `IAM_A_IND2: t = {2'(s.ptr2s[SECTOR_BITS-1:0]), s.ptr2l}; // RQ4
      default: t = {2'b00, a};
    endcase
    return t;
  endfunction : ind_target

  function automatic logic is_ind(input logic [9:0] a);
    return a == {2'b00, `IAM_A_IND0} || a == {2'b00, `IAM_A_IND1} ||
           a == {2'b00, `IAM_A_IND2};
  endfunction : is_ind

  // Register read mux for sector 0 special registers handled here.
  function automatic logic [7:0] reg_read(input logic [9:0] a, input iam_state_t s);
    logic [7:0] v;
    v = 8'h00;
    if (a[9:8] == 2'b00) begin
      unique case (a[7:0])
        `IAM_A_PTR0: v = s.ptr0;
        `IAM_A_PTR1L: v = s.ptr1l;
        `IAM_A_PTR1S: v = s.ptr1s;
        `IAM_A_PTR2L: v = s.ptr2l;
        `IAM_A_PTR2S: v = s.ptr2s;
        `IAM_A_ACC: v = s.acc;
        `IAM_A_TABLE_POINTER_LOW: v = s.table_pointer_low;
        `IAM_A_TABLE_POINTER_HIGH: v = s.table_pointer_high;
        `IAM_A_TABLE_HIGH_RESULT: v = s.table_high_result;
        `IAM_A_UNLOCK: v = s.unlock;
        default: v = 8'h00;
      endcase
    end
    return v;
  endfunction : reg_read

  function automatic logic is_local(input logic [9:0] a);
    logic r;
    r = 1'b0;
    if (a[9:8] == 2'b00) begin
      unique case (a[7:0])
        `IAM_A_PTR0, `IAM_A_PTR1L, `IAM_A_PTR1S, `IAM_A_PTR2L, `IAM_A_PTR2S,
        `IAM_A_ACC, `IAM_A_PCL, `IAM_A_TABLE_POINTER_LOW, `IAM_A_TABLE_POINTER_HIGH, `IAM_A_TABLE_HIGH_RESULT,
        `IAM_A_UNLOCK: r = 1'b1;
        default: r = 1'b0;
      endcase
    end
    return r;
  endfunction : is_local

  logic [9:0] eff;
  logic ind_hit;
  logic rd;
  logic wr;
  logic osc_rise;
  logic unlock_hit;
  logic [15:0] tbl_word;

  always_comb begin
    s_d = s_q;
    rd = OP == 2'(iam_pkg::IAM_OP_READ);
    wr = OP == 2'(iam_pkg::IAM_OP_WRITE);
    ind_hit = is_ind({2'b00, ADDR[7:0]}) && ADDR[9:8] == 2'b00;
    // Ten-bit operand: upper bits pick the sector, low byte the location.
    eff = ind_hit ? ind_target(ADDR[7:0], s_q) : ADDR; // RQ2 RQ5 RQ6
    s_d.osc_sync = {s_q.osc_sync[1:0], SLOW_OSC};
    s_d.wake_sync = {s_q.wake_sync[0], WAKE};
    osc_rise = s_q.osc_sync[1] && !s_q.osc_sync[2];
    s_d.mem_rd = 1'b0;
    s_d.mem_wr = 1'b0;
    s_d.pc_load = 1'b0;
    s_d.dummy = 1'b0;
    s_d.opt_sel = 1'b0;
    s_d.rdata = 8'h00;
    if (rd) begin
      // A pointer aimed back at an indirect register reads as zero.
      if (ind_hit && is_ind(eff)) begin
        s_d.rdata = 8'h00; // RQ7
      end else if (is_local(eff)) begin
        s_d.rdata = reg_read(eff, s_q);
      end else begin
        s_d.mem_rd = 1'b1;
        s_d.mem_addr = eff;
      end
    end
    if (wr && !(ind_hit && is_ind(eff))) begin // RQ7
      if (is_local(eff)) begin
        unique case (eff[7:0])
          `IAM_A_PTR0: s_d.ptr0 = WDATA; // RQ1
          `IAM_A_PTR1L: s_d.ptr1l = WDATA; // RQ1
          `IAM_A_PTR1S: s_d.ptr1s = WDATA; // RQ1
          `IAM_A_PTR2L: s_d.ptr2l = WDATA; // RQ1
          `IAM_A_PTR2S: s_d.ptr2s = WDATA; // RQ1
          `IAM_A_ACC: s_d.acc = WDATA;
          `IAM_A_TABLE_POINTER_LOW: s_d.table_pointer_low = WDATA; // RQ11
          `IAM_A_TABLE_POINTER_HIGH: s_d.table_pointer_high = WDATA; // RQ11
          `IAM_A_TABLE_HIGH_RESULT: s_d.table_high_result = WDATA;
          `IAM_A_PCL: begin
            s_d.pc_jump = {PC_NOW[PC_WIDTH-1:8], WDATA}; // RQ9
            s_d.pc_load = 1'b1; // RQ9
            s_d.dummy = 1'b1; // RQ10
          end
          `IAM_A_UNLOCK: s_d.unlock = WDATA; // RQ21
          default: s_d.rdata = s_q.rdata;
        endcase
      end else begin
        s_d.mem_wr = 1'b1;
        s_d.mem_addr = eff;
        s_d.mem_wdata = WDATA;
      end
    end
    // Increment or decrement is a read-modify-write the core expresses as a step.
    if (PTR_STEP[0]) begin
      unique case (PTR_STEP_SEL)
        3'h0: s_d.ptr0 = PTR_STEP[1] ? s_q.ptr0 - 8'h01 : s_q.ptr0 + 8'h01; // RQ1
        3'h1: s_d.ptr1l = PTR_STEP[1] ? s_q.ptr1l - 8'h01 : s_q.ptr1l + 8'h01; // RQ1
        3'h2: s_d.ptr1s = PTR_STEP[1] ? s_q.ptr1s - 8'h01 : s_q.ptr1s + 8'h01; // RQ1
        3'h3: s_d.ptr2l = PTR_STEP[1] ? s_q.ptr2l - 8'h01 : s_q.ptr2l + 8'h01; // RQ1
        3'h4: s_d.ptr2s = PTR_STEP[1] ? s_q.ptr2s - 8'h01 : s_q.ptr2s + 8'h01; // RQ1
        3'h5: s_d.table_pointer_low = PTR_STEP[1] ? s_q.table_pointer_low - 8'h01 : s_q.table_pointer_low + 8'h01; // RQ11
        3'h6: s_d.table_pointer_high = PTR_STEP[1] ? s_q.table_pointer_high - 8'h01 : s_q.table_pointer_high + 8'h01; // RQ11
        default: s_d.table_pointer_high = s_q.table_pointer_high;
      endcase
    end
    if (ACC_LOAD) begin
      s_d.acc = ACC_IN; // RQ8
    end
    // Unlock sequencer: only a 55 followed in the very next cycle by AA maps.
    // The timer is settled first so that a completed pair wins over an expiry.
    unlock_hit = wr && eff == {2'b00, `IAM_A_UNLOCK};
    if (s_q.map_on && osc_rise) begin
      if (s_q.slow_cnt + 3'h1 >= `IAM_MAP_SLOW_PERIODS) begin
        s_d.map_on = 1'b0; // RQ17
      end else begin
        s_d.slow_cnt = s_q.slow_cnt + 3'h1; // RQ17
      end
    end
    unique case (s_q.ust)
      iam_pkg::IAM_ST_IDLE, iam_pkg::IAM_ST_MAPPED: begin
        if (unlock_hit && WDATA == `IAM_PAT_FIRST) begin
          s_d.ust = iam_pkg::IAM_ST_ARMED; // RQ14
        end else if (!s_d.map_on) begin
          s_d.ust = iam_pkg::IAM_ST_IDLE; // RQ17
        end
      end
      iam_pkg::IAM_ST_ARMED: begin
        if (unlock_hit && WDATA == `IAM_PAT_SECOND) begin
          s_d.ust = iam_pkg::IAM_ST_MAPPED; // RQ14
          s_d.map_on = 1'b1; // RQ14
          s_d.slow_cnt = 3'h0; // RQ18
        end else if (unlock_hit && WDATA == `IAM_PAT_FIRST) begin
          s_d.ust = iam_pkg::IAM_ST_ARMED; // RQ14
        end else begin
          // Arming never ends a window that is already open.
          s_d.ust = s_d.map_on ? iam_pkg::IAM_ST_MAPPED : iam_pkg::IAM_ST_IDLE; // RQ15
        end
      end
      default: s_d.ust = iam_pkg::IAM_ST_IDLE;
    endcase
    if (s_q.wake_sync[1]) begin
      s_d.unlock = `IAM_UNLOCK_RST; // RQ22
    end
    // Table read: fetch address this cycle, capture result the next.
    s_d.tbl_pend = 1'b0;
    if (TBL_READ) begin
      s_d.prog_addr = TBL_LAST_PAGE ? {{(PC_WIDTH-8){1'b1}}, s_q.table_pointer_low} :
                      {s_q.table_pointer_high[PC_WIDTH-9:0], s_q.table_pointer_low};
      s_d.tbl_pend = 1'b1;
      s_d.tbl_dest = eff;
      s_d.opt_sel = s_q.map_on && s_d.prog_addr[PC_WIDTH-1:8] == '1 &&
                    s_q.table_pointer_low >= `IAM_OPT_BASE; // RQ13 RQ16
      s_d.opt_addr = s_q.table_pointer_low[5:0]; // RQ16
    end
    if (s_q.tbl_pend) begin
      tbl_word = s_q.opt_sel ? OPT_WORD : PROG_WORD;
      s_d.table_high_result = tbl_word[15:8]; // RQ12
      s_d.mem_wr = 1'b1; // RQ12
      s_d.mem_addr = s_q.tbl_dest;
      s_d.mem_wdata = tbl_word[7:0];
    end else begin
      tbl_word = 16'h0000;
    end
    if (SYS_RST) begin
      s_d = '0;
      s_d.ust = iam_pkg::IAM_ST_IDLE;
      s_d.unlock = `IAM_UNLOCK_RST; // RQ21
    end
  end

  always_ff @(posedge REF_CLK) begin
    s_q <= s_d;
  end

  assign RDATA = s_q.rdata;
  assign MEM_ADDR = s_q.mem_addr;
  assign MEM_RD = s_q.mem_rd;
  assign MEM_WR = s_q.mem_wr;
  assign MEM_WDATA = s_q.mem_wdata;
  assign ACC = s_q.acc;
  assign PC_JUMP = s_q.pc_jump;
  assign PC_LOAD = s_q.pc_load;
  assign DUMMY_CYCLE = s_q.dummy;
  assign PROG_ADDR = s_q.prog_addr;
  assign OPT_ADDR = s_q.opt_addr;
  assign OPT_SEL = s_q.opt_sel;
  assign MAP_ACTIVE = s_q.map_on;
endmodule : iam_core

// file: tb/iam_core_assertions.sv
`timescale 1ns/1ps
`include "iam_defs.svh"
module iam_core_assertions #(
  parameter int PC_WIDTH = 11
) (
  input wire logic REF_CLK,
  input wire logic SYS_RST,
  input wire logic [1:0] OP,
  input wire logic [9:0] ADDR,
  input wire logic [7:0] WDATA,
  input wire logic ACC_LOAD,
  input wire logic [7:0] ACC_IN,
  input wire logic [9:0] MEM_ADDR,
  input wire logic MEM_WR,
  input wire logic [7:0] MEM_WDATA,
  input wire logic [7:0] ACC,
  input wire logic [PC_WIDTH-1:0] PC_JUMP,
  input wire logic [PC_WIDTH-1:0] PC_NOW,
  input wire logic PC_LOAD,
  input wire logic DUMMY_CYCLE,
  input wire logic [PC_WIDTH-1:0] PROG_ADDR,
  input wire logic [5:0] OPT_ADDR,
  input wire logic OPT_SEL,
  input wire logic MAP_ACTIVE
);
  logic wr_op;
  assign wr_op = OP == iam_pkg::IAM_OP_WRITE;
  default clocking @(posedge REF_CLK); endclocking
  default disable iff (SYS_RST);
  sequence s_first;
    wr_op && ADDR == `IAM_A_UNLOCK && WDATA == `IAM_PAT_FIRST;
  endsequence
  sequence s_second;
    wr_op && ADDR == `IAM_A_UNLOCK && WDATA == `IAM_PAT_SECOND;
  endsequence
  a_unlock_opens: assert property (s_first ##1 s_second |=> MAP_ACTIVE)
    else $error("mapping not opened by unlock pair");
  // Only the completed pair may open the window; anything else keeps it shut.
  a_stays_locked: assert property (!MAP_ACTIVE && !(wr_op && ADDR == `IAM_A_UNLOCK
    && WDATA == `IAM_PAT_SECOND && $past(wr_op && ADDR == `IAM_A_UNLOCK
    && WDATA == `IAM_PAT_FIRST)) |=> !MAP_ACTIVE)
    else $error("mapping opened without unlock pair");
  a_pcl_jump: assert property (wr_op && ADDR == `IAM_A_PCL
    |=> PC_LOAD && PC_JUMP == {$past(PC_NOW[PC_WIDTH-1:8]), $past(WDATA)})
    else $error("page jump wrong");
  a_pcl_dummy: assert property (wr_op && ADDR == `IAM_A_PCL |=> DUMMY_CYCLE)
    else $error("no dummy cycle after jump");
  a_sector0_only: assert property (wr_op && ADDR == `IAM_A_IND0
    |=> !MEM_WR || MEM_ADDR[9:8] == 2'h0)
    else $error("pointer zero left sector zero");
  a_ext_direct: assert property (wr_op && ADDR[9:8] != 2'h0
    |=> MEM_WR && MEM_ADDR == $past(ADDR) && MEM_WDATA == $past(WDATA))
    else $error("extended direct write wrong");
  a_acc_load: assert property (ACC_LOAD |=> ACC == $past(ACC_IN))
    else $error("accumulator not loaded");
  a_opt_window: assert property (OPT_SEL
    |-> &PROG_ADDR[PC_WIDTH-1:6] && OPT_ADDR == PROG_ADDR[5:0])
    else $error("option word outside last-page window");
endmodule : iam_core_assertions
bind iam_core iam_core_assertions #(.PC_WIDTH(PC_WIDTH)) iam_core_assertions_i (.*);

// file: tb/tb.sv
`timescale 1ns/1ps
`include "iam_defs.svh"
module tb;
  logic REF_CLK = 0, SYS_RST = 1, ACC_LOAD = 0, TBL_READ = 0, TBL_LAST_PAGE = 0;
  logic SLOW_OSC = 0, WAKE = 0, MEM_RD, MEM_WR, PC_LOAD, DUMMY_CYCLE, OPT_SEL, MAP_ACTIVE;
  logic [1:0] OP = 0;
  logic [9:0] ADDR = 0, MEM_ADDR;
  logic [7:0] WDATA = 0, ACC_IN = 0, RDATA, MEM_WDATA, ACC, v, s, tp, hp;
  logic [2:0] PTR_STEP = 0, PTR_STEP_SEL = 0;
  logic [15:0] PROG_WORD = 0, OPT_WORD = 0;
  logic [10:0] PC_JUMP, PROG_ADDR, PC_NOW = 0;
  logic [5:0] OPT_ADDR;
  logic [7:0] pa [7] = '{8'h01, 8'h03, 8'h04, 8'h0c, 8'h0d, 8'h07, 8'h09};
  int err_count = 0, total_checks = 0, n = 0, t, slow_cnt = 0;
  iam_core iam_core_i (.*);
  initial forever #10 REF_CLK = ~REF_CLK;
  // The slow oscillator runs at sixteen system cycles a period.
  always @(negedge REF_CLK) begin
    slow_cnt <= slow_cnt + 1;
    SLOW_OSC <= slow_cnt[3];
  end
  task chk(input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  task put(input logic [1:0] o, input logic [9:0] a, input logic [7:0] d);
    OP = o;
    ADDR = a;
    WDATA = d;
    @(negedge REF_CLK);
  endtask : put
  task wr8(input logic [7:0] a, input logic [7:0] d);
    put(2'h2, {2'h0, a}, d);
  endtask : wr8
  task rd(input logic [7:0] a, input logic [7:0] e);
    put(2'h1, {2'h0, a}, 8'h00);
    chk(RDATA, e);
    put(2'h0, 10'h000, 8'h00);
  endtask : rd
  task wm(input logic [9:0] a, input logic [7:0] d, input logic [9:0] ea);
    put(2'h2, a, d);
    chk(MEM_WR, 1'b1);
    chk(MEM_ADDR, ea);
    chk(MEM_WDATA, d);
    put(2'h0, 10'h000, 8'h00);
  endtask : wm
  // Nothing may run between the two writes, which is why software masks interrupts.
  task unlock;
    wr8(`IAM_A_UNLOCK, `IAM_PAT_FIRST);
    wr8(`IAM_A_UNLOCK, `IAM_PAT_SECOND);
    put(2'h0, 10'h000, 8'h00);
  endtask : unlock
  // Program address a table read must fetch, from the pointers the bench wrote.
  function automatic logic [10:0] tbl_addr(input logic lp);
    return {lp ? 3'h7 : hp[2:0], tp};
  endfunction : tbl_addr
  task tbl(input logic lp, input logic os);
    OP = 2'h0;
    TBL_READ = 1;
    TBL_LAST_PAGE = lp;
    ADDR = 10'h180;
    @(negedge REF_CLK);
    TBL_READ = 0;
    chk(PROG_ADDR, tbl_addr(lp));
    chk(OPT_SEL, os);
    chk(OPT_ADDR, tp[5:0]);
    t = 0;
    while (MEM_WR !== 1'b1 && t < 4) begin
      @(negedge REF_CLK);
      t++;
    end
    chk(16'(t), 16'h0001);
    chk(MEM_WDATA, os ? OPT_WORD[7:0] : PROG_WORD[7:0]);
    chk(MEM_ADDR, 10'h180);
    rd(`IAM_A_TABLE_HIGH_RESULT, os ? OPT_WORD[15:8] : PROG_WORD[15:8]);
  endtask : tbl
  task done;
    n++;
    $display("test %0d done", n);
  endtask : done
  task finish_test;
    $display("checks=%0d mismatches=%0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : finish_test
  initial begin
    #100000;
    err_count++;
    finish_test();
  end
  initial begin
    void'($urandom(37286));
    PROG_WORD = 16'($urandom);
    OPT_WORD = ~PROG_WORD;
    repeat (12) @(negedge REF_CLK);
    SYS_RST = 0;
    rd(`IAM_A_UNLOCK, 8'h00);
    for (int i = 0; i < 5; i++) begin
      v = 8'($urandom);
      if (i == 2 || i == 4) v[7:2] = 6'h00;
      wr8(pa[i], v);
      rd(pa[i], v);
    end
    wr8(`IAM_A_PTR0, 8'h80);
    PTR_STEP = 3'h1;
    @(negedge REF_CLK);
    PTR_STEP = 3'h0;
    rd(`IAM_A_PTR0, 8'h81);
    PTR_STEP = 3'h3;
    @(negedge REF_CLK);
    PTR_STEP = 3'h0;
    rd(`IAM_A_PTR0, 8'h80);
    for (int i = 0; i < 7; i++) begin
      v = 8'($urandom);
      wr8(pa[i], v);
      PTR_STEP_SEL = 3'(i);
      PTR_STEP = {1'b0, i[0], 1'b1};
      @(negedge REF_CLK);
      PTR_STEP = 3'h0;
      rd(pa[i], i[0] ? v - 8'h01 : v + 8'h01);
    end
    done();
    v = 8'($urandom) | 8'h80;
    s = 8'($urandom) & 8'h03;
    wr8(`IAM_A_PTR0, v);
    wm({2'h0, `IAM_A_IND0}, ~v, {2'h0, v});
    wr8(`IAM_A_PTR1S, s);
    wr8(`IAM_A_PTR1L, v);
    wm({2'h0, `IAM_A_IND1}, s, {s[1:0], v});
    wr8(`IAM_A_PTR2S, 8'h00);
    wr8(`IAM_A_PTR2L, `IAM_A_IND0);
    wr8(`IAM_A_IND2, 8'h5a);
    chk(MEM_WR, 1'b0);
    put(2'h1, {2'h0, `IAM_A_IND2}, 8'h00);
    chk(RDATA, 8'h00);
    chk(MEM_RD, 1'b0);
    put(2'h1, {2'h2, v}, 8'h00);
    chk(MEM_RD, 1'b1);
    chk(MEM_ADDR, {2'h2, v});
    put(2'h0, 10'h000, 8'h00);
    for (int i = 1; i < 4; i++) begin
      v = 8'($urandom);
      wm({i[1:0], v}, ~v, {i[1:0], v});
    end
    done();
    ACC_IN = 8'($urandom);
    ACC_LOAD = 1;
    @(negedge REF_CLK);
    ACC_LOAD = 0;
    chk(ACC, ACC_IN);
    v = 8'($urandom);
    PC_NOW = 11'($urandom);
    wr8(`IAM_A_PCL, v);
    chk(PC_LOAD, 1'b1);
    chk(PC_JUMP, {PC_NOW[10:8], v});
    chk(DUMMY_CYCLE, 1'b1);
    put(2'h0, 10'h000, 8'h00);
    chk(DUMMY_CYCLE, 1'b0);
    done();
    // A wrong second value, then a one-cycle gap, must both be refused.
    wr8(`IAM_A_UNLOCK, `IAM_PAT_FIRST);
    wr8(`IAM_A_UNLOCK, 8'h5a);
    put(2'h0, 10'h000, 8'h00);
    chk(MAP_ACTIVE, 1'b0);
    wr8(`IAM_A_UNLOCK, `IAM_PAT_FIRST);
    put(2'h0, 10'h000, 8'h00);
    wr8(`IAM_A_UNLOCK, `IAM_PAT_SECOND);
    put(2'h0, 10'h000, 8'h00);
    chk(MAP_ACTIVE, 1'b0);
    tp = 8'hc0 | 8'($urandom & 8'h3f);
    hp = 8'h07;
    wr8(`IAM_A_TABLE_POINTER_LOW, tp);
    wr8(`IAM_A_TABLE_POINTER_HIGH, hp);
    tbl(1'b1, 1'b0);
    unlock();
    chk(MAP_ACTIVE, 1'b1);
    rd(`IAM_A_UNLOCK, `IAM_PAT_SECOND);
    tbl(1'b1, 1'b1);
    tbl(1'b0, 1'b1);
    hp = 8'h03;
    wr8(`IAM_A_TABLE_POINTER_HIGH, hp);
    tbl(1'b0, 1'b0);
    repeat (20) @(negedge REF_CLK);
    chk(MAP_ACTIVE, 1'b1);
    unlock();
    repeat (40) @(negedge REF_CLK);
    chk(MAP_ACTIVE, 1'b1);
    repeat (32) @(negedge REF_CLK);
    chk(MAP_ACTIVE, 1'b0);
    tbl(1'b1, 1'b0);
    done();
    unlock();
    WAKE = 1;
    repeat (4) @(negedge REF_CLK);
    WAKE = 0;
    repeat (2) @(negedge REF_CLK);
    rd(`IAM_A_UNLOCK, 8'h00);
    chk(MAP_ACTIVE, 1'b1);
    done();
    // A reset in mid-run must close the window and clear the low table pointer.
    SYS_RST = 1;
    @(negedge REF_CLK);
    SYS_RST = 0;
    chk(MAP_ACTIVE, 1'b0);
    rd(`IAM_A_TABLE_POINTER_LOW, 8'h00);
    rd(`IAM_A_UNLOCK, 8'h00);
    done();
    finish_test();
  end
endmodule : tb
